// *** include/iag_pkg.sv ***
// Constants and types shared by the interrupt acceptance gate.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
`default_nettype none
package iag_pkg;
	// Register byte offsets
	localparam logic [7:0] IAG_ENABLE_OFS = 8'h00;
	localparam logic [7:0] IAG_STATUS_OFS = 8'h04;
	localparam logic [7:0] IAG_SYSCTL_OFS = 8'h08;
	localparam logic [7:0] IAG_STATE_OFS  = 8'h0C;
	// Field positions and reset values
	localparam int          IAG_NMI_EDGE_BIT  = 0;
	localparam logic [7:0]  IAG_ENABLE_RST    = 8'h00;
	localparam logic [7:0]  IAG_STATUS_RST    = 8'h00;
	localparam logic        IAG_NMI_EDGE_RST  = 1'b0;
	// Opcodes that enter and leave break mode
	localparam logic [15:0] IAG_OP_BREAK      = 16'h5770;
	localparam logic [15:0] IAG_OP_RET_BREAK  = 16'h56F0;
	// AHB transfer type
	localparam logic [1:0]  IAG_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  IAG_HTRANS_SEQ    = 2'h3;
	// Kind of the instruction the core is executing
	typedef enum logic [1:0] {
		IAG_KIND_NORMAL = 2'h0,
		IAG_KIND_CCR    = 2'h1,
		IAG_KIND_BMOV_W = 2'h3,
		IAG_KIND_BMOV_B = 2'h2
	} iag_kind_t;
endpackage
`default_nettype wire

// *** rtl/iag_gate.sv ***
// Interrupt acceptance gate: flags, enables, edge detection and the
// decision whether the core may take an exception at a boundary.
// Assumes the core reports instruction and transfer-cycle boundaries
// on clk_sys_i and that irq and nmi pins are asynchronous.
`default_nettype none
module iag_gate
	import iag_pkg::*;
#(
	parameter int N_IRQ = 8
) (
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               rst_n_i,
	// AHB-Lite slave
	input  wire logic               hsel_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic [31:0]        hwdata_i,
	input  wire logic               hready_i,
	output logic      [31:0]        hrdata_o,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	// Pins
	input  wire logic [N_IRQ-1:0]   irq_pin_i,
	input  wire logic               nmi_pin_i,
	// Core sequencer
	input  wire logic               instr_end_i,
	input  wire logic [15:0]        instr_op_i,
	input  wire iag_kind_t          instr_kind_i,
	input  wire logic               xfer_end_i,
	input  wire logic               irq_mask_i,
	// Requests and acceptance toward the core
	output logic                    irq_req_o,
	output logic                    take_irq_o,
	output logic                    take_nmi_o,
	output logic [$clog2(N_IRQ)-1:0] take_vec_o,
	output logic                    push_next_pc_o,
	output logic                    brk_exc_o,
	output logic                    break_mode_o,
	output logic                    wdt_stop_o
);
	localparam int VW = $clog2(N_IRQ);

	// Lowest index has highest priority
	function automatic logic [VW-1:0] prio_enc(input logic [N_IRQ-1:0] v);
		logic [VW-1:0] r;
		r = '0;
		for (int i = N_IRQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = VW'(i);
			end
		end
		return r;
	endfunction

	// Pin synchronisers; stage one feeds only stage two
	// A pin held high through reset reads as a rising edge once released
	logic [N_IRQ-1:0] irq_s1_r, irq_s2_r, irq_s3_r;
	logic             nmi_s1_r, nmi_s2_r, nmi_s3_r;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_s1_r <= '0;
			irq_s2_r <= '0;
			irq_s3_r <= '0;
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			nmi_s3_r <= 1'b0;
		end else begin
			irq_s1_r <= irq_pin_i;
			irq_s2_r <= irq_s1_r;
			irq_s3_r <= irq_s2_r;
			nmi_s1_r <= nmi_pin_i;
			nmi_s2_r <= nmi_s1_r;
			nmi_s3_r <= nmi_s2_r;
		end
	end

	// AHB address phase capture
	logic       aw_r, aw_nxt, ar_r, ar_nxt;
	logic [7:0] aa_r, aa_nxt;
	logic       ahb_go;
	assign ahb_go = hsel_i && hready_i && (htrans_i == IAG_HTRANS_NONSEQ || htrans_i == IAG_HTRANS_SEQ);
	always_comb begin
		aw_nxt = ahb_go && hwrite_i;
		ar_nxt = ahb_go && !hwrite_i;
		aa_nxt = ahb_go ? {haddr_i[7:2], 2'b00} : aa_r;
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_r <= 1'b0;
			ar_r <= 1'b0;
			aa_r <= '0;
		end else begin
			aw_r <= aw_nxt;
			ar_r <= ar_nxt;
			aa_r <= aa_nxt;
		end
	end
	// Zero wait states, every response OKAY; hsize is only ever a word
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// Register and gating state
	logic [N_IRQ-1:0] en_r, en_nxt, flag_r, flag_nxt;
	logic [N_IRQ-1:0] held_en_r, held_en_nxt, held_flag_r, held_flag_nxt;
	logic             edge_sel_r, edge_sel_nxt, nmi_pend_r, nmi_pend_nxt;
	logic             brk_r, brk_nxt;
	logic             t_irq_r, t_irq_nxt, t_nmi_r, t_nmi_nxt, pnp_r, pnp_nxt, bexc_r, bexc_nxt;
	logic [VW-1:0]    t_vec_r, t_vec_nxt;
	logic [31:0]      rd_r, rd_nxt;

	logic [N_IRQ-1:0] irq_edge, eff_pend;
	logic             nmi_edge, sel_ok, ccr_end, brk_now, nmi_at_end, nmi_mid, irq_take;
	logic [VW-1:0]    sel_vec;

	// Acceptance decision
	always_comb begin
		irq_edge = irq_s2_r & ~irq_s3_r;
		nmi_edge = edge_sel_r ? (nmi_s2_r & ~nmi_s3_r) : (~nmi_s2_r & nmi_s3_r);
		// Cleared enables and flags still count until the boundary
		eff_pend = (flag_r | held_flag_r) & (en_r | held_en_r);
		sel_ok   = |eff_pend;
		sel_vec  = prio_enc(eff_pend);
		ccr_end  = instr_end_i && instr_kind_i == IAG_KIND_CCR;
		brk_now  = instr_end_i && !brk_r && instr_op_i == IAG_OP_BREAK;
		// Byte move has no mid-transfer take, so NMI waits for its end
		nmi_at_end = instr_end_i && nmi_pend_r && !brk_r && !ccr_end && !brk_now;
		nmi_mid    = xfer_end_i && !instr_end_i && instr_kind_i == IAG_KIND_BMOV_W
		             && nmi_pend_r && !brk_r;
		irq_take = instr_end_i && sel_ok && !irq_mask_i && !brk_r && !ccr_end
		           && !brk_now && !nmi_at_end;
	end

	// Next-state of registers and gating
	always_comb begin
		en_nxt        = en_r;
		flag_nxt      = flag_r;
		edge_sel_nxt  = edge_sel_r;
		held_en_nxt   = held_en_r;
		held_flag_nxt = held_flag_r;
		// Software write first, hardware set after so the set wins
		if (aw_r && aa_r == IAG_ENABLE_OFS) begin
			en_nxt = hwdata_i[N_IRQ-1:0];
		end
		if (aw_r && aa_r == IAG_STATUS_OFS) begin
			flag_nxt = flag_r & hwdata_i[N_IRQ-1:0];
		end
		if (aw_r && aa_r == IAG_SYSCTL_OFS) begin
			edge_sel_nxt = hwdata_i[IAG_NMI_EDGE_BIT];
		end
		flag_nxt = flag_nxt | irq_edge;
		// Snapshot refreshes at every instruction boundary, ending the grace
		if (instr_end_i) begin
			held_en_nxt   = en_r;
			held_flag_nxt = flag_r;
		end
		nmi_pend_nxt = (nmi_pend_r && !(nmi_at_end || nmi_mid)) || nmi_edge;
		brk_nxt = brk_r;
		if (brk_now) begin
			brk_nxt = 1'b1;
		end else if (instr_end_i && brk_r && instr_op_i == IAG_OP_RET_BREAK) begin
			brk_nxt = 1'b0;
		end
		t_irq_nxt = irq_take;
		t_nmi_nxt = nmi_at_end || nmi_mid;
		t_vec_nxt = irq_take ? sel_vec : t_vec_r;
		pnp_nxt   = nmi_mid;
		bexc_nxt  = brk_now;
		// Read data registered for the data phase
		// Next values for enable, status and sysctl, so a read right behind a write to them already sees it
		rd_nxt = 32'h0000_0000;
		if (ar_nxt) begin
			case ({haddr_i[7:2], 2'b00})
				IAG_ENABLE_OFS: rd_nxt = 32'(en_nxt);
				IAG_STATUS_OFS: rd_nxt = 32'(flag_nxt);
				IAG_SYSCTL_OFS: rd_nxt = 32'(edge_sel_nxt);
				IAG_STATE_OFS:  rd_nxt = {29'h0, nmi_pend_r, sel_ok, brk_r};
				default:        rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	// State registers; reset clears break mode
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_r        <= IAG_ENABLE_RST[N_IRQ-1:0];
			flag_r      <= IAG_STATUS_RST[N_IRQ-1:0];
			held_en_r   <= IAG_ENABLE_RST[N_IRQ-1:0];
			held_flag_r <= IAG_STATUS_RST[N_IRQ-1:0];
			edge_sel_r  <= IAG_NMI_EDGE_RST;
			nmi_pend_r  <= 1'b0;
			brk_r       <= 1'b0;
			t_irq_r     <= 1'b0;
			t_nmi_r     <= 1'b0;
			t_vec_r     <= '0;
			pnp_r       <= 1'b0;
			bexc_r      <= 1'b0;
			rd_r        <= 32'h0000_0000;
		end else begin
			en_r        <= en_nxt;
			flag_r      <= flag_nxt;
			held_en_r   <= held_en_nxt;
			held_flag_r <= held_flag_nxt;
			edge_sel_r  <= edge_sel_nxt;
			nmi_pend_r  <= nmi_pend_nxt;
			brk_r       <= brk_nxt;
			t_irq_r     <= t_irq_nxt;
			t_nmi_r     <= t_nmi_nxt;
			t_vec_r     <= t_vec_nxt;
			pnp_r       <= pnp_nxt;
			bexc_r      <= bexc_nxt;
			rd_r        <= rd_nxt;
		end
	end

	// Outputs
	assign hrdata_o       = rd_r;
	assign irq_req_o      = sel_ok && !brk_r;
	assign take_irq_o     = t_irq_r;
	assign take_nmi_o     = t_nmi_r;
	assign take_vec_o     = t_vec_r;
	assign push_next_pc_o = pnp_r;
	assign brk_exc_o      = bexc_r;
	assign break_mode_o   = brk_r;
	assign wdt_stop_o     = brk_r;

	// Checks
	// Boundary gating; the break opcode boundary gives the break exception only
	ccr_no_take_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ccr_end |=> !take_irq_o && !take_nmi_o) else $error("take after ccr instruction");
	ccr_one_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		instr_end_i && instr_kind_i == IAG_KIND_NORMAL && instr_op_i != IAG_OP_BREAK
		&& sel_ok && !irq_mask_i && !brk_r && !nmi_pend_r
		|=> take_irq_o) else $error("acceptance not resumed");
	brk_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		break_mode_o |-> ##1 (!take_irq_o && !take_nmi_o) || !$past(break_mode_o))
		else $error("take in break mode");
	brk_enter_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		instr_end_i && !break_mode_o && instr_op_i == IAG_OP_BREAK |=> break_mode_o && brk_exc_o)
		else $error("break not entered");
	brk_leave_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		instr_end_i && break_mode_o && instr_op_i == IAG_OP_RET_BREAK |=> !break_mode_o)
		else $error("break not left");
	// Block moves
	bmov_b_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		xfer_end_i && !instr_end_i && instr_kind_i == IAG_KIND_BMOV_B |=> !take_nmi_o && !take_irq_o)
		else $error("take inside byte move");
	nmi_mid_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		xfer_end_i && !instr_end_i && instr_kind_i == IAG_KIND_BMOV_W && nmi_pend_r && !break_mode_o
		|=> take_nmi_o && push_next_pc_o && !take_irq_o) else $error("mid-move nmi missed");
	bmov_w_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!instr_end_i |=> !take_irq_o) else $error("maskable take off boundary");
	push_nmi_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		push_next_pc_o |-> take_nmi_o) else $error("push without nmi");
	// Flags and enables
	clr_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		aw_r && aa_r == IAG_STATUS_OFS && !hwdata_i[0] && !irq_edge[0] |=> !flag_r[0])
		else $error("write 0 did not clear");
	keep_one_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		aw_r && aa_r == IAG_STATUS_OFS && hwdata_i[1] && flag_r[1] |=> flag_r[1])
		else $error("write 1 cleared a flag");
	set_wins_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		irq_edge[0] |=> flag_r[0]) else $error("flag set lost");
	grace_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(en_r[0]) && !instr_end_i && !$past(instr_end_i) && $past(flag_r[0]) && flag_r[0]
		|-> irq_req_o || break_mode_o) else $error("enable clear took early");
	// Priority and the single request toward the core
	prio_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		irq_take && eff_pend[0] |=> take_vec_o == '0) else $error("priority wrong");
	nmi_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		instr_end_i && nmi_pend_r && !break_mode_o && instr_kind_i != IAG_KIND_CCR && instr_op_i != IAG_OP_BREAK
		|=> take_nmi_o && !take_irq_o) else $error("nmi lost to maskable");
	one_take_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		take_irq_o |-> !take_nmi_o) else $error("two takes at once");
	// NMI edge polarity
	edge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		edge_sel_r && $rose(nmi_s2_r) |=> nmi_pend_r) else $error("nmi edge missed");
	fall_edge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!edge_sel_r && $fell(nmi_s2_r) |=> nmi_pend_r) else $error("falling nmi edge missed");
	rise_skip_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!edge_sel_r && $rose(nmi_s2_r) && !nmi_pend_r |=> !nmi_pend_r) else $error("wrong nmi edge taken");
endmodule
`default_nettype wire

// *** tb/iag_core_model.sv ***
// Core sequencer model: pulses instruction and transfer boundaries.
// Assumes each task starts just after a rising edge of clk_sys_i.
`default_nettype none
module iag_core_model
	import iag_pkg::*;
(
	// Clock
	input  wire logic       clk_sys_i,
	// Acceptance from the gate
	input  wire logic       take_irq_i,
	input  wire logic       take_nmi_i,
	input  wire logic       push_next_pc_i,
	input  wire logic       brk_exc_i,
	// Boundaries toward the gate
	output var  logic       instr_end_o,
	output var  logic [15:0] instr_op_o,
	output var  iag_kind_t  instr_kind_o,
	output var  logic       xfer_end_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle until the first boundary
	initial begin
		instr_end_o  = 1'b0;
		xfer_end_o   = 1'b0;
		instr_op_o   = 16'h0000;
		instr_kind_o = IAG_KIND_NORMAL;
	end
	// One boundary pulse; the takes are read in the cycle they stand
	task automatic step(input iag_kind_t k, input logic [15:0] op, input logic x, output logic [3:0] tk);
		instr_kind_o <= k;
		instr_op_o   <= op;
		instr_end_o  <= !x;
		xfer_end_o   <= x;
		@(posedge clk_sys_i);
		instr_end_o <= 1'b0;
		xfer_end_o  <= 1'b0;
		instr_op_o  <= ~op; // Opcode is not held past its boundary
		@(posedge clk_sys_i);
		tk = {take_nmi_i, take_irq_i, push_next_pc_i, brk_exc_i};
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt acceptance gate.
// Assumes the gate and the core model share clk_sys_i at 10 MHz.
`default_nettype none
module testbench
	import iag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst_n, hsel, hwrite, nmi_pin, irq_mask, hresp, irq_req, take_irq, take_nmi;
	logic        push_pc, brk_exc, brk_mode, wdt_stop, instr_end, xfer_end;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] instr_op;
	logic [7:0]  irq_pin, pend, en;
	logic [3:0]  tk;
	logic [2:0]  hsize, take_vec;
	logic [1:0]  htrans;
	iag_kind_t   instr_kind;
	wire logic   hready;
	int          num_errors, n_compared;
	integer      seed;
	// Clock and design under test
	always #50 clk_sys = ~clk_sys;
	iag_gate dut_u (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .irq_pin_i(irq_pin), .nmi_pin_i(nmi_pin), .instr_end_i(instr_end),
		.instr_op_i(instr_op), .instr_kind_i(instr_kind), .xfer_end_i(xfer_end), .irq_mask_i(irq_mask),
		.irq_req_o(irq_req), .take_irq_o(take_irq), .take_nmi_o(take_nmi), .take_vec_o(take_vec),
		.push_next_pc_o(push_pc), .brk_exc_o(brk_exc), .break_mode_o(brk_mode), .wdt_stop_o(wdt_stop));
	iag_core_model core_u (.clk_sys_i(clk_sys), .take_irq_i(take_irq), .take_nmi_i(take_nmi),
		.push_next_pc_i(push_pc), .brk_exc_i(brk_exc), .instr_end_o(instr_end), .instr_op_o(instr_op),
		.instr_kind_o(instr_kind), .xfer_end_o(xfer_end));
	// Comparison and verdict
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Single AHB-Lite word transfer; waits as long as the slave stalls
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		htrans <= IAG_HTRANS_NONSEQ;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h00000000, r);
		chk($sformatf("reg %h", a), exp, r);
	endtask
	// Boundary with expected {nmi, irq, push, brk}
	task automatic at(input iag_kind_t k, input logic [15:0] op, input logic x, input logic [3:0] exp);
		core_u.step(k, op, x, tk);
		chk("takes", {28'h0000000, exp}, {28'h0000000, tk});
	endtask
	// Pins pass a two-flop synchroniser, so allow settling time
	task automatic pins(input logic [7:0] b);
		irq_pin <= 8'h00;
		@(posedge clk_sys);
		irq_pin <= b;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic nmi_lvl(input logic v);
		nmi_pin <= v;
		repeat (4) @(posedge clk_sys);
	endtask
	function automatic logic [2:0] lowest(input logic [7:0] v);
		lowest = 3'h0;
		for (int i = 7; i >= 0; i--) if (v[i]) lowest = 3'(i);
	endfunction
	// A hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{clk_sys, rst_n, hsel, hwrite, nmi_pin, irq_mask} = 6'h00;
		{haddr, hwdata, htrans, irq_pin} = 74'h0;
		hsize = 3'h2;
		seed = 32'h58CF2F55;
		num_errors = 0;
		n_compared = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd_chk(IAG_ENABLE_OFS, {24'h000000, IAG_ENABLE_RST});
		rd_chk(IAG_STATUS_OFS, {24'h000000, IAG_STATUS_RST});
		rd_chk(IAG_SYSCTL_OFS, {31'h00000000, IAG_NMI_EDGE_RST});
		rd_chk(IAG_STATE_OFS, 32'h00000000);
		rd_chk(8'h10, 32'h00000000);
		// Random pins and enables; a masked boundary first lets old grace expire
		for (int i = 0; i < 8; i++) begin
			pend = 8'($random(seed));
			en = (i == 0) ? 8'hFF : 8'($random(seed));
			wr(IAG_STATUS_OFS, 32'h00000000);
			wr(IAG_ENABLE_OFS, {24'h000000, en});
			irq_mask <= 1'b1;
			at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h0);
			irq_mask <= 1'b0;
			pins(pend);
			rd_chk(IAG_STATUS_OFS, {24'h000000, pend});
			chk("irq_req", {31'h0, |(pend & en)}, {31'h0, irq_req});
			at(IAG_KIND_NORMAL, 16'h0000, 1'b0, {1'b0, |(pend & en), 2'b00});
			if (|(pend & en)) chk("vector", {29'h0, lowest(pend & en)}, {29'h0, take_vec});
		end
		wr(IAG_ENABLE_OFS, 32'h000000FF);
		pins(8'h01);
		at(IAG_KIND_CCR, 16'h0000, 1'b0, 4'h0);
		at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h4);
		// Enable or flag cleared after a boundary still counts at the next one
		for (int j = 0; j < 2; j++) begin
			wr(IAG_STATUS_OFS, 32'h00000000);
			wr(IAG_ENABLE_OFS, 32'h00000001);
			irq_mask <= 1'b1;
			at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h0);
			pins(8'h01);
			at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h0);
			if (j == 0) wr(IAG_ENABLE_OFS, 32'h00000000);
			else wr(IAG_STATUS_OFS, 32'h000000FE);
			irq_mask <= 1'b0;
			at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h4);
			at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h0);
		end
		// Flag raised between read and write-back is lost
		pins(8'h02);
		rd_chk(IAG_STATUS_OFS, 32'h00000002);
		pins(8'h04);
		wr(IAG_STATUS_OFS, 32'h00000002);
		rd_chk(IAG_STATUS_OFS, 32'h00000002);
		wr(IAG_STATUS_OFS, 32'h000000FD);
		rd_chk(IAG_STATUS_OFS, 32'h00000000);
		// Byte move holds off the falling-edge request until it ends
		nmi_lvl(1'b1);
		at(IAG_KIND_BMOV_B, 16'h0000, 1'b1, 4'h0);
		nmi_lvl(1'b0);
		at(IAG_KIND_BMOV_B, 16'h0000, 1'b1, 4'h0);
		at(IAG_KIND_BMOV_B, 16'h0000, 1'b0, 4'h8);
		// Word move: only the non-maskable one, at a transfer boundary
		pins(8'h01);
		at(IAG_KIND_BMOV_W, 16'h0000, 1'b1, 4'h0);
		nmi_lvl(1'b1);
		nmi_lvl(1'b0);
		at(IAG_KIND_BMOV_W, 16'h0000, 1'b1, 4'hA);
		for (int c = 2; c != 0; c--) at(IAG_KIND_BMOV_W, 16'h0000, 1'b1, 4'h0);
		at(IAG_KIND_BMOV_W, 16'h0000, 1'b0, 4'h4);
		wr(IAG_SYSCTL_OFS, 32'h00000001);
		rd_chk(IAG_SYSCTL_OFS, 32'h00000001);
		nmi_lvl(1'b1);
		at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h8);
		nmi_lvl(1'b0);
		// Falling edge ignored; flag 0 is still pending and enabled, so it is taken
		at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h4);
		// Break mode, its return, and a reset while in it
		at(IAG_KIND_NORMAL, IAG_OP_BREAK, 1'b0, 4'h1);
		chk("break", 32'h3, {30'h0, brk_mode, wdt_stop});
		at(IAG_KIND_NORMAL, 16'h0000, 1'b0, 4'h0);
		chk("irq_req", 32'h0, {31'h0, irq_req});
		rd_chk(IAG_STATE_OFS, 32'h00000003);
		at(IAG_KIND_NORMAL, IAG_OP_RET_BREAK, 1'b0, 4'h0);
		chk("break", 32'h0, {30'h0, brk_mode, wdt_stop});
		at(IAG_KIND_NORMAL, IAG_OP_BREAK, 1'b0, 4'h1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("break", 32'h0, {30'h0, brk_mode, wdt_stop});
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd_chk(IAG_ENABLE_OFS, 32'h00000000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
